// ===== lhp_bus_if.sv
`timescale 1ns/100ps
`include "lhp_cfg.svh"
interface lhp_bus_if;
  logic mode_sel_drv;
  logic mode_sel_oe;
  logic mode_sel_lvl;
  logic cpu_type_sel_lo;
  logic cpu_type_sel_hi;
  logic cpu_clk;
  logic wr_rw;
  logic read_or_data_strobe;
  logic address_latch_strobe;
  logic cs_n;
  logic [`LHP_ADDR_W-1:0] addr;
  logic [`LHP_DATA_W-1:0] data_host;
  logic data_host_oe;
  logic [`LHP_DATA_W-1:0] data_dev;
  logic data_dev_oe;
  logic [`LHP_DATA_W-1:0] data_lvl;
  logic transfer_done_out;
  logic transfer_done_oe;
  logic rx_mute_pin;
  logic done_lvl;
  logic [`LHP_CHAN_NUM-1:0] tx_section_enable;
  logic [`LHP_CHAN_NUM-1:0] tx_line_clock;
  logic [`LHP_CHAN_NUM-1:0] tx_positive_rail_in;
  logic [`LHP_CHAN_NUM-1:0] tx_negative_rail_in;
  logic [`LHP_CHAN_NUM-1:0] tx_line_pos_out;
  logic [`LHP_CHAN_NUM-1:0] tx_line_neg_out;
  logic [`LHP_CHAN_NUM-1:0] tx_line_oe;
  // Undriven mode pin floats to its pull-up, which selects hardware mode
  assign mode_sel_lvl = mode_sel_oe ? mode_sel_drv : 1'b1;
  assign data_lvl = data_dev_oe ? data_dev : (data_host_oe ? data_host : 8'h00);
  // Done pin doubles as the receive mute input when the device does not drive it
  assign done_lvl = transfer_done_oe ? transfer_done_out : rx_mute_pin;
  modport dev (
    input mode_sel_lvl, cpu_type_sel_lo, cpu_type_sel_hi, cpu_clk, wr_rw, read_or_data_strobe,
    input address_latch_strobe, cs_n, addr, data_lvl, done_lvl, tx_section_enable,
    input tx_line_clock, tx_positive_rail_in, tx_negative_rail_in,
    output data_dev, data_dev_oe, transfer_done_out, transfer_done_oe,
    output tx_line_pos_out, tx_line_neg_out, tx_line_oe
  );
  modport host (
    output mode_sel_drv, mode_sel_oe, cpu_type_sel_lo, cpu_type_sel_hi, cpu_clk, wr_rw,
    output read_or_data_strobe, address_latch_strobe, cs_n, addr, data_host, data_host_oe,
    output rx_mute_pin, tx_section_enable, tx_line_clock, tx_positive_rail_in, tx_negative_rail_in,
    input mode_sel_lvl, data_lvl, done_lvl, tx_line_pos_out, tx_line_neg_out, tx_line_oe
  );
endinterface

// ===== lhp_cfg.svh
`ifndef LHP_CFG_SVH
`define LHP_CFG_SVH
// Widths
`define LHP_CHAN_NUM 4
`define LHP_ADDR_W 8
`define LHP_DATA_W 8
// Register offsets and reset values
`define LHP_CHAN_CTRL_BASE 8'h00
`define LHP_CHAN_CTRL_STRIDE 8'h10
`define LHP_CHAN_CTRL_RST 3'h2
`define LHP_TX_SRC_CTRL_OFS 8'h42
`define LHP_TX_SRC_CTRL_RST 1'b0
`define LHP_STATUS_OFS 8'h44
// Field positions
`define LHP_CH_TXON_BIT 0
`define LHP_CH_RXON_BIT 1
`define LHP_CH_AOS_BIT 2
`define LHP_HANDOVER_BIT 6
// Timing
`define LHP_SYS_CLK_HZ 125000000
`define LHP_SYS_CLK_PERIOD_NS 8
`define LHP_E1_TCLK_HZ 2048000
`define LHP_T1_TCLK_HZ 1544000
`define LHP_E1_MARK_NS 244
`define LHP_T1_MARK_NS 324
`define LHP_CPU_CLK_HALF 2
`endif

// ===== lhp_liu_asserts.sv
`timescale 1ns/100ps
`include "lhp_cfg.svh"
// Watches the joined bus; done polarity follows the strobe-style pin
module lhp_liu_asserts (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic mode_sel_lvl,
  input wire logic cpu_type_sel_lo,
  input wire logic wr_rw,
  input wire logic read_or_data_strobe,
  input wire logic cs_n,
  input wire logic data_dev_oe,
  input wire logic transfer_done_out,
  input wire logic transfer_done_oe,
  input wire logic [`LHP_CHAN_NUM-1:0] tx_section_enable,
  input wire logic [`LHP_CHAN_NUM-1:0] tx_line_pos_out,
  input wire logic [`LHP_CHAN_NUM-1:0] tx_line_neg_out,
  input wire logic [`LHP_CHAN_NUM-1:0] tx_line_oe
);
  logic oe_r;
  logic sty_r;
  logic done_act;
  logic strobe_act;
  logic steady;
  // Last pin state, so a mode or style change is not mistaken for a transfer
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oe_r <= 1'b0;
      sty_r <= 1'b0;
    end else begin
      oe_r <= transfer_done_oe;
      sty_r <= cpu_type_sel_lo;
    end
  end
  // Done is high-true for split strobes, low-true for the data strobe style
  assign done_act = transfer_done_oe && (cpu_type_sel_lo ? !transfer_done_out : transfer_done_out);
  assign strobe_act = cpu_type_sel_lo ? !read_or_data_strobe : !(wr_rw && read_or_data_strobe);
  assign steady = transfer_done_oe && oe_r && (sty_r == cpu_type_sel_lo) && !mode_sel_lvl;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_done_after_select: assert property ($rose(done_act) && steady |-> $past(!cs_n))
    else $error("done rose without chip select");
  a_answer_bounded: assert property (steady && $fell(cs_n) && strobe_act |-> ##[1:8] done_act)
    else $error("no done after strobe");
  a_done_release: assert property (steady && done_act && cs_n |=> !done_act)
    else $error("done held after release");
  a_ignore_no_select: assert property (steady && !done_act && cs_n |=> !done_act)
    else $error("done without chip select");
  a_hw_no_drive: assert property (mode_sel_lvl |-> !transfer_done_oe && !data_dev_oe)
    else $error("bus driven in hardware mode");
  a_read_strobe_drive: assert property (data_dev_oe && !cpu_type_sel_lo |-> !cs_n && !read_or_data_strobe)
    else $error("data driven without read strobe");
  a_rw_high_drive: assert property (data_dev_oe && cpu_type_sel_lo |-> !cs_n && wr_rw)
    else $error("data driven on write");
  a_hw_pin_enable: assert property (mode_sel_lvl |-> tx_line_oe == tx_section_enable)
    else $error("line enable differs from pins");
  a_off_lines_quiet: assert property ((tx_line_oe == 4'h0) [*2] |-> (tx_line_pos_out | tx_line_neg_out) == 4'h0)
    else $error("disabled line active");
  a_rails_apart: assert property ((tx_line_pos_out & tx_line_neg_out) == 4'h0)
    else $error("both rails high");
  c_split_done: cover property (steady && done_act && !cpu_type_sel_lo);
  c_ds_done: cover property (steady && done_act && cpu_type_sel_lo);
  c_neg_rail: cover property (tx_line_neg_out[0]);
endmodule

// ===== lhp_liu_dev.sv
// Operation
// R1: Each channel samples data on own transmit clock
// R2: Far end supplies transmit clock at line rate
// R3: Line pulse timing comes from master clock
// R4: Hardware mode: pin high sends all ones
// R5: Hardware mode: enable pin powers transmitter only
// R6: Disabled transmitter tristates both line outputs
// R7: Hardware mode: receivers always on
// R8: Host mode: receivers switch on/off individually
// R9: Host mode: register bits switch transmitters
// R10: Handover bit gives transmit enable to pins
// R11: Mode pin high or open means hardware
// R12: Write strobe low with select low writes
// R13: Read strobe low with select low reads
// R14: Read/write line high reads, low writes
// R15: Data strobe low with select marks transfer
// R16: Address latched on strobe falling edge
// R17: Strobes ignored while chip select high
// R18: Ready driven high on completion
// R19: Acknowledge driven low on completion
// R20: Host mode: all-ones pins become bus signals
// R21: Type select pins choose bus protocol
// R22: Done shown after strobe, dropped at release
`timescale 1ns/100ps
`include "lhp_cfg.svh"
module lhp_liu_dev import lhp_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  lhp_bus_if.dev bus,
  input wire logic e1_mode_i,
  output logic hw_mode_o,
  output logic [`LHP_CHAN_NUM-1:0] rx_enable_o,
  output logic rx_mute_o,
  output logic [`LHP_CHAN_NUM-1:0] tx_enable_o,
  output logic [`LHP_CHAN_NUM-1:0] tx_all_ones_o
);
  localparam logic [5:0] E1_MARK_CYC = 6'(`LHP_E1_MARK_NS / `LHP_SYS_CLK_PERIOD_NS);
  localparam logic [5:0] T1_MARK_CYC = 6'(`LHP_T1_MARK_NS / `LHP_SYS_CLK_PERIOD_NS);

  lhp_dev_state_type state_r;
  lhp_cpu_type_type cpu_type;
  logic hw_mode;
  logic style_ds;
  logic sync_bus;
  logic ale_prev_r;
  logic cpu_clk_prev_r;
  logic sync_ok;
  logic strobe_act;
  logic is_write;
  logic req;
  logic write_r;
  logic [`LHP_ADDR_W-1:0] addr_r;
  logic [`LHP_DATA_W-1:0] rdata_r;
  logic [`LHP_DATA_W-1:0] rd_mux;
  logic [2:0] ch_ctrl_r [`LHP_CHAN_NUM];
  logic handover_r;
  logic [`LHP_CHAN_NUM-1:0] aos_pins;
  logic [`LHP_CHAN_NUM-1:0] rx_bits;
  logic [`LHP_CHAN_NUM-1:0] tx_bits;
  logic [`LHP_CHAN_NUM-1:0] aos_bits;
  logic [5:0] mark_cyc;

  // Mode and bus protocol decode
  assign hw_mode = bus.mode_sel_lvl; // R11
  assign cpu_type = lhp_cpu_type_type'({bus.cpu_type_sel_hi, bus.cpu_type_sel_lo}); // R21
  assign style_ds = (cpu_type == LHP_CPU_ASYNC_DS) || (cpu_type == LHP_CPU_SYNC_DS); // R21
  assign sync_bus = (cpu_type == LHP_CPU_SYNC_RW) || (cpu_type == LHP_CPU_SYNC_DS); // R21
  assign hw_mode_o = hw_mode;
  assign mark_cyc = e1_mode_i ? E1_MARK_CYC : T1_MARK_CYC;

  // Shared pins: bus signals in host mode, all-ones requests in hardware mode
  assign aos_pins = {bus.cs_n, bus.address_latch_strobe, bus.read_or_data_strobe, bus.wr_rw}; // R20

  // Edge history of the address strobe and processor clock
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ale_prev_r <= 1'b0;
      cpu_clk_prev_r <= 1'b0;
    end else begin
      ale_prev_r <= bus.address_latch_strobe;
      cpu_clk_prev_r <= bus.cpu_clk;
    end
  end

  // Address register loads on the falling edge of the latch strobe
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_r <= 8'h00;
    end else if (!hw_mode && ale_prev_r && !bus.address_latch_strobe) begin
      addr_r <= bus.addr; // R16
    end
  end

  // Synchronous types only accept a strobe on a rising processor clock edge
  assign sync_ok = !sync_bus || (bus.cpu_clk && !cpu_clk_prev_r); // R21
  always_comb begin
    if (style_ds) begin
      strobe_act = !bus.read_or_data_strobe; // R15
      is_write = !bus.wr_rw; // R14
    end else begin
      strobe_act = !bus.wr_rw || !bus.read_or_data_strobe; // R12 R13
      is_write = !bus.wr_rw; // R12
    end
  end
  assign req = !hw_mode && !bus.cs_n && strobe_act && sync_ok; // R17

  // Access sequencer: one access per strobe, done held until release
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= LHP_DS_IDLE;
    end else begin
      case (state_r)
        LHP_DS_IDLE: begin
          if (req) begin
            state_r <= LHP_DS_ACCESS;
          end
        end
        LHP_DS_ACCESS: begin
          state_r <= LHP_DS_DONE; // R22
        end
        LHP_DS_DONE: begin
          if (hw_mode || bus.cs_n || !strobe_act) begin
            state_r <= LHP_DS_IDLE; // R22
          end
        end
        default: begin
          state_r <= LHP_DS_IDLE;
        end
      endcase
    end
  end

  // Direction is frozen at the start so a late read/write change cannot retarget the cycle
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      write_r <= 1'b0;
    end else if (state_r == LHP_DS_IDLE && req) begin
      write_r <= is_write; // R12 R14
    end
  end

  // Handover register; only bit 6 is stored, the rest reads as zero
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      handover_r <= `LHP_TX_SRC_CTRL_RST;
    end else if (state_r == LHP_DS_ACCESS && write_r && addr_r == `LHP_TX_SRC_CTRL_OFS) begin
      handover_r <= bus.data_lvl[`LHP_HANDOVER_BIT]; // R10
    end
  end

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    rd_mux = 8'h00;
    if (addr_r == `LHP_TX_SRC_CTRL_OFS) begin
      rd_mux[`LHP_HANDOVER_BIT] = handover_r;
    end
    if (addr_r == `LHP_STATUS_OFS) begin
      rd_mux = {rx_enable_o, tx_enable_o};
    end
    for (int k = 0; k < `LHP_CHAN_NUM; k++) begin
      if (addr_r == 8'(`LHP_CHAN_CTRL_BASE + k * `LHP_CHAN_CTRL_STRIDE)) begin
        rd_mux = {5'h00, ch_ctrl_r[k]};
      end
    end
  end

  // Read data is captured once so the bus sees a stable value for the whole done phase
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= 8'h00;
    end else if (state_r == LHP_DS_ACCESS && !write_r) begin
      rdata_r <= rd_mux; // R13
    end
  end

  // Bus outputs: completion polarity follows the strobe style
  assign bus.transfer_done_out = style_ds ? (state_r != LHP_DS_DONE) : (state_r == LHP_DS_DONE); // R18 R19
  assign bus.transfer_done_oe = !hw_mode;
  assign bus.data_dev = rdata_r;
  assign bus.data_dev_oe = (state_r == LHP_DS_DONE) && !write_r && !bus.cs_n && !hw_mode; // R13 R11
  assign rx_mute_o = hw_mode && bus.done_lvl;

  genvar i;
  generate
    for (i = 0; i < `LHP_CHAN_NUM; i++) begin : g_ch
      localparam logic [7:0] CH_OFS = 8'(`LHP_CHAN_CTRL_BASE + i * `LHP_CHAN_CTRL_STRIDE);
      logic tclk_prev_r;
      logic pol_r;
      logic pos_out_r;
      logic neg_out_r;
      logic [5:0] mark_cnt_r;
      logic tclk_rise;

      // Channel control register
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          ch_ctrl_r[i] <= `LHP_CHAN_CTRL_RST;
        end else if (state_r == LHP_DS_ACCESS && write_r && addr_r == CH_OFS) begin
          ch_ctrl_r[i] <= bus.data_lvl[2:0];
        end
      end
      assign rx_bits[i] = ch_ctrl_r[i][`LHP_CH_RXON_BIT];
      assign tx_bits[i] = ch_ctrl_r[i][`LHP_CH_TXON_BIT];
      assign aos_bits[i] = ch_ctrl_r[i][`LHP_CH_AOS_BIT];

      // Effective controls per mode
      assign rx_enable_o[i] = hw_mode ? 1'b1 : rx_bits[i]; // R7 R8
      assign tx_enable_o[i] = (hw_mode || handover_r) ? bus.tx_section_enable[i] : tx_bits[i]; // R5 R9 R10
      assign tx_all_ones_o[i] = hw_mode ? aos_pins[i] : aos_bits[i]; // R4

      assign tclk_rise = bus.tx_line_clock[i] && !tclk_prev_r;

      // Data is taken on the channel clock edge; mark width is timed by the master clock
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          tclk_prev_r <= 1'b0;
          pol_r <= 1'b0;
          pos_out_r <= 1'b0;
          neg_out_r <= 1'b0;
          mark_cnt_r <= 6'h00;
        end else begin
          tclk_prev_r <= bus.tx_line_clock[i];
          if (!tx_enable_o[i]) begin
            pos_out_r <= 1'b0;
            neg_out_r <= 1'b0;
            mark_cnt_r <= 6'h00;
          end else if (tclk_rise) begin
            if (tx_all_ones_o[i]) begin
              pol_r <= !pol_r; // R4
              pos_out_r <= !pol_r;
              neg_out_r <= pol_r;
            end else begin
              pos_out_r <= bus.tx_positive_rail_in[i]; // R1
              neg_out_r <= bus.tx_negative_rail_in[i]; // R1
            end
            mark_cnt_r <= mark_cyc; // R3
          end else if (mark_cnt_r != 6'h00) begin
            mark_cnt_r <= mark_cnt_r - 6'h01; // R3
            if (mark_cnt_r == 6'h01) begin
              pos_out_r <= 1'b0;
              neg_out_r <= 1'b0;
            end
          end
        end
      end
      assign bus.tx_line_pos_out[i] = pos_out_r;
      assign bus.tx_line_neg_out[i] = neg_out_r;
      assign bus.tx_line_oe[i] = tx_enable_o[i]; // R6
    end
  endgenerate
endmodule

// ===== lhp_liu_host.sv
`timescale 1ns/100ps
`include "lhp_cfg.svh"
module lhp_liu_host import lhp_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  lhp_bus_if.host bus,
  input wire logic host_mode_i,
  input wire logic [1:0] cpu_type_i,
  input wire logic e1_mode_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [`LHP_ADDR_W-1:0] addr_i,
  input wire logic [`LHP_DATA_W-1:0] wdata_i,
  output logic ack_o,
  output logic busy_o,
  output logic [`LHP_DATA_W-1:0] rdata_o,
  input wire logic [`LHP_CHAN_NUM-1:0] all_ones_i,
  input wire logic [`LHP_CHAN_NUM-1:0] tx_pin_enable_i,
  input wire logic [`LHP_CHAN_NUM-1:0] tx_pos_i,
  input wire logic [`LHP_CHAN_NUM-1:0] tx_neg_i,
  input wire logic rx_mute_i
);
  localparam logic [31:0] E1_INC = 32'((64'(`LHP_E1_TCLK_HZ) << 32) / 64'(`LHP_SYS_CLK_HZ));
  localparam logic [31:0] T1_INC = 32'((64'(`LHP_T1_TCLK_HZ) << 32) / 64'(`LHP_SYS_CLK_HZ));
  localparam logic [1:0] CPU_HALF = 2'(`LHP_CPU_CLK_HALF - 1);

  lhp_host_state_type state_r;
  logic style_ds;
  logic done_seen;
  logic we_r;
  logic [`LHP_ADDR_W-1:0] addr_r;
  logic [`LHP_DATA_W-1:0] wdata_r;
  logic [31:0] acc_r;
  logic msb_prev_r;
  logic [`LHP_CHAN_NUM-1:0] pos_r;
  logic [`LHP_CHAN_NUM-1:0] neg_r;
  logic [1:0] cpu_cnt_r;
  logic cpu_clk_r;
  logic strobe;

  assign style_ds = cpu_type_i[0]; // R21
  assign done_seen = style_ds ? !bus.done_lvl : bus.done_lvl; // R18 R19

  // Mode pin is pulled low for host mode and left open for hardware mode
  assign bus.mode_sel_drv = 1'b0; // R11
  assign bus.mode_sel_oe = host_mode_i; // R11
  assign bus.cpu_type_sel_lo = cpu_type_i[0]; // R21
  assign bus.cpu_type_sel_hi = cpu_type_i[1]; // R21
  assign bus.cpu_clk = cpu_clk_r;
  assign bus.rx_mute_pin = rx_mute_i;
  assign bus.tx_section_enable = tx_pin_enable_i;
  assign bus.tx_line_clock = {`LHP_CHAN_NUM{acc_r[31]}};
  assign bus.tx_positive_rail_in = pos_r;
  assign bus.tx_negative_rail_in = neg_r;

  // Phase accumulator makes the line-rate transmit clock from the system clock
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_r <= 32'h00000000;
      msb_prev_r <= 1'b0;
      pos_r <= 4'h0;
      neg_r <= 4'h0;
    end else begin
      acc_r <= acc_r + (e1_mode_i ? E1_INC : T1_INC); // R2
      msb_prev_r <= acc_r[31];
      // Data moves on the falling clock edge, half a bit clear of the sampling edge
      if (msb_prev_r && !acc_r[31]) begin
        pos_r <= tx_pos_i;
        neg_r <= tx_neg_i;
      end
    end
  end

  // Processor clock divider for the synchronous bus types
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cpu_cnt_r <= 2'h0;
      cpu_clk_r <= 1'b0;
    end else if (cpu_cnt_r == CPU_HALF) begin
      cpu_cnt_r <= 2'h0;
      cpu_clk_r <= !cpu_clk_r;
    end else begin
      cpu_cnt_r <= cpu_cnt_r + 2'h1;
    end
  end

  // Bus cycle sequencer: address phase, strobe until done, release
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= LHP_HS_IDLE;
      we_r <= 1'b0;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      rdata_o <= 8'h00;
    end else begin
      case (state_r)
        LHP_HS_IDLE: begin
          if (req_i && host_mode_i) begin
            we_r <= we_i;
            addr_r <= addr_i;
            wdata_r <= wdata_i;
            state_r <= LHP_HS_ALE_HI;
          end
        end
        LHP_HS_ALE_HI: begin
          state_r <= LHP_HS_ALE_LO;
        end
        LHP_HS_ALE_LO: begin
          state_r <= LHP_HS_STROBE; // R16
        end
        LHP_HS_STROBE: begin
          if (done_seen) begin
            if (!we_r) begin
              rdata_o <= bus.data_lvl;
            end
            state_r <= LHP_HS_RELEASE;
          end
        end
        LHP_HS_RELEASE: begin
          state_r <= LHP_HS_IDLE;
        end
        default: begin
          state_r <= LHP_HS_IDLE;
        end
      endcase
    end
  end

  // Pin drive: bus signals in host mode, all-ones requests otherwise
  assign strobe = (state_r == LHP_HS_STROBE);
  always_comb begin
    if (!host_mode_i) begin
      bus.wr_rw = all_ones_i[0]; // R20
      bus.read_or_data_strobe = all_ones_i[1];
      bus.address_latch_strobe = all_ones_i[2];
      bus.cs_n = all_ones_i[3];
    end else if (style_ds) begin
      bus.wr_rw = !we_r; // R14
      bus.read_or_data_strobe = !strobe; // R15
      bus.address_latch_strobe = (state_r == LHP_HS_ALE_HI);
      bus.cs_n = !strobe; // R17
    end else begin
      bus.wr_rw = !(strobe && we_r); // R12
      bus.read_or_data_strobe = !(strobe && !we_r); // R13
      bus.address_latch_strobe = (state_r == LHP_HS_ALE_HI);
      bus.cs_n = !strobe; // R17
    end
  end
  assign bus.addr = addr_r;
  assign bus.data_host = wdata_r;
  assign bus.data_host_oe = host_mode_i && strobe && we_r;
  assign ack_o = (state_r == LHP_HS_RELEASE);
  assign busy_o = (state_r != LHP_HS_IDLE);
endmodule

// ===== lhp_pkg.sv
package lhp_pkg;
  // Processor type: bit 0 picks strobe style, bit 1 picks synchronous operation
  typedef enum logic [1:0] {
    LHP_CPU_ASYNC_RW = 2'h0,
    LHP_CPU_ASYNC_DS = 2'h1,
    LHP_CPU_SYNC_RW = 2'h2,
    LHP_CPU_SYNC_DS = 2'h3
  } lhp_cpu_type_type;
  typedef enum logic [1:0] {
    LHP_DS_IDLE = 2'h0,
    LHP_DS_ACCESS = 2'h1,
    LHP_DS_DONE = 2'h3
  } lhp_dev_state_type;
  typedef enum logic [2:0] {
    LHP_HS_IDLE = 3'h0,
    LHP_HS_ALE_HI = 3'h1,
    LHP_HS_ALE_LO = 3'h3,
    LHP_HS_STROBE = 3'h2,
    LHP_HS_RELEASE = 3'h6
  } lhp_host_state_type;
endpackage

// ===== tb_liu_host_port_and_tx_control.sv
`timescale 1ns/100ps
`include "lhp_cfg.svh"
module tb_liu_host_port_and_tx_control;
  logic clk_sys_i;
  logic rstn_i;
  logic host_mode;
  logic [1:0] cpu_type;
  logic e1_mode;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic busy;
  logic [7:0] rdata;
  logic [3:0] all_ones;
  logic [3:0] tx_pin_en;
  logic [3:0] tx_pos;
  logic [3:0] tx_neg;
  logic hw_mode;
  logic [3:0] rx_en;
  logic [3:0] tx_en;
  logic [3:0] aos_out;
  logic [3:0] tx_en2;
  logic rx_mute;
  logic mute = 1'b0;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  lhp_bus_if lhp_bus_if_inst ();
  // Second bus: the bench plays a host that breaks the select rule
  lhp_bus_if bus2 ();
  lhp_liu_dev lhp_liu_dev_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus(lhp_bus_if_inst), .e1_mode_i(e1_mode),
    .hw_mode_o(hw_mode), .rx_enable_o(rx_en), .rx_mute_o(rx_mute), .tx_enable_o(tx_en), .tx_all_ones_o(aos_out));
  lhp_liu_dev lhp_liu_dev_inst_2 (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus(bus2), .e1_mode_i(e1_mode),
    .hw_mode_o(), .rx_enable_o(), .rx_mute_o(), .tx_enable_o(tx_en2), .tx_all_ones_o());
  lhp_liu_host lhp_liu_host_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus(lhp_bus_if_inst),
    .host_mode_i(host_mode), .cpu_type_i(cpu_type), .e1_mode_i(e1_mode), .req_i(req), .we_i(we), .addr_i(addr),
    .wdata_i(wdata), .ack_o(ack), .busy_o(busy), .rdata_o(rdata), .all_ones_i(all_ones),
    .tx_pin_enable_i(tx_pin_en), .tx_pos_i(tx_pos), .tx_neg_i(tx_neg), .rx_mute_i(mute));
  lhp_liu_asserts lhp_liu_asserts_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .mode_sel_lvl(lhp_bus_if_inst.mode_sel_lvl), .cpu_type_sel_lo(lhp_bus_if_inst.cpu_type_sel_lo),
    .wr_rw(lhp_bus_if_inst.wr_rw), .read_or_data_strobe(lhp_bus_if_inst.read_or_data_strobe),
    .cs_n(lhp_bus_if_inst.cs_n), .data_dev_oe(lhp_bus_if_inst.data_dev_oe),
    .transfer_done_out(lhp_bus_if_inst.transfer_done_out), .transfer_done_oe(lhp_bus_if_inst.transfer_done_oe),
    .tx_section_enable(lhp_bus_if_inst.tx_section_enable), .tx_line_pos_out(lhp_bus_if_inst.tx_line_pos_out),
    .tx_line_neg_out(lhp_bus_if_inst.tx_line_neg_out), .tx_line_oe(lhp_bus_if_inst.tx_line_oe));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // Hang guard, well above the fifteen hundred or so cycles the run needs
  always @(posedge clk_sys_i) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      failures = failures + 1;
      complete_run();
    end
  end
  task automatic complete_run();
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One register access through the host end; req is dropped once taken
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd);
    int n;
    {we, addr, wdata} = {w, a, d};
    req = 1'b1;
    @(negedge clk_sys_i);
    req = 1'b0;
    chk({7'h00, busy}, 8'h01);
    n = 0;
    while (ack !== 1'b1 && n < 40) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk({7'h00, ack}, 8'h01);
    rd = rdata;
    @(negedge clk_sys_i);
  endtask
  task automatic b2(input logic ale, input logic cs, input logic wr, input logic oe);
    {bus2.address_latch_strobe, bus2.cs_n, bus2.wr_rw, bus2.data_host_oe} = {ale, cs, wr, oe};
    @(negedge clk_sys_i);
  endtask
  task automatic t_hw();
    all_ones = 4'hA;
    tx_pin_en = 4'h5;
    mute = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    chk({7'h00, hw_mode}, 8'h01);
    chk({7'h00, rx_mute}, 8'h01);
    chk({4'h0, rx_en}, 8'h0F);
    chk({4'h0, aos_out}, 8'h0A);
    chk({4'h0, tx_en}, 8'h05);
    chk({4'h0, lhp_bus_if_inst.tx_line_oe}, 8'h05);
    all_ones = 4'h0;
    tx_pin_en = 4'h0;
    mute = 1'b0;
  endtask
  task automatic t_regs(input logic [1:0] t);
    logic [7:0] rd;
    logic [2:0] v [4];
    logic [3:0] txe;
    logic [3:0] rxe;
    logic [3:0] ao;
    // Style changes go through hardware mode so the done pin is not driven meanwhile
    host_mode = 1'b0;
    cpu_type = t;
    all_ones = 4'hF;
    repeat (3) @(negedge clk_sys_i);
    host_mode = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    chk({7'h00, lhp_bus_if_inst.done_lvl}, {7'h00, t[0]});
    for (int k = 0; k < 4; k++) begin
      v[k] = 3'(t + 3 * k);
      {ao[k], rxe[k], txe[k]} = v[k];
      acc(1'b1, 8'(16 * k), {5'h00, v[k]}, rd);
    end
    for (int k = 0; k < 4; k++) begin
      acc(1'b0, 8'(16 * k), 8'h00, rd);
      chk(rd, {5'h00, v[k]});
    end
    acc(1'b0, `LHP_STATUS_OFS, 8'h00, rd);
    chk(rd, {rxe, txe});
    chk({4'h0, tx_en}, {4'h0, txe});
    chk({4'h0, aos_out}, {4'h0, ao});
    chk({7'h00, hw_mode}, 8'h00);
  endtask
  task automatic t_handover();
    logic [7:0] rd;
    tx_pin_en = 4'hA;
    for (int k = 0; k < 4; k++) acc(1'b1, 8'(16 * k), {7'h00, ~k[0]}, rd);
    acc(1'b1, `LHP_TX_SRC_CTRL_OFS, 8'hFF, rd);
    acc(1'b0, `LHP_TX_SRC_CTRL_OFS, 8'h00, rd);
    chk(rd, 8'h40);
    chk({4'h0, tx_en}, 8'h0A);
    acc(1'b1, `LHP_TX_SRC_CTRL_OFS, 8'h00, rd);
    chk({4'h0, tx_en}, 8'h05);
    acc(1'b1, `LHP_STATUS_OFS, 8'hFF, rd);
    acc(1'b0, `LHP_STATUS_OFS, 8'h00, rd);
    chk(rd, 8'h05);
    acc(1'b0, 8'h50, 8'h00, rd);
    chk(rd, 8'h00);
  endtask
  // Mark width is counted in master clock cycles at the falling edge
  task automatic t_line(input logic e1m, input logic ao);
    int n;
    int w;
    logic neg;
    host_mode = 1'b0;
    e1_mode = e1m;
    tx_pin_en = 4'h1;
    all_ones = {3'h0, ao};
    tx_pos = {3'h0, ~ao};
    neg = 1'b0;
    n = 0;
    w = 0;
    repeat (100) @(negedge clk_sys_i);
    // Skip a mark already under way so only a whole one is timed
    while (lhp_bus_if_inst.tx_line_pos_out[0] === 1'b1 && n < 600) begin
      @(negedge clk_sys_i);
      n++;
    end
    while (lhp_bus_if_inst.tx_line_pos_out[0] !== 1'b1 && n < 600) begin
      @(negedge clk_sys_i);
      n++;
    end
    while (lhp_bus_if_inst.tx_line_pos_out[0] === 1'b1 && w < 100) begin
      @(negedge clk_sys_i);
      w++;
    end
    chk(8'(w), e1m ? 8'h1E : 8'h28);
    repeat (300) begin
      @(negedge clk_sys_i);
      neg = neg | lhp_bus_if_inst.tx_line_neg_out[0];
    end
    chk({7'h00, neg}, {7'h00, ao});
    tx_pin_en = 4'h0;
    tx_pos = 4'h0;
    all_ones = 4'h0;
  endtask
  task automatic t_fault();
    logic seen;
    seen = 1'b0;
    {bus2.addr, bus2.data_host, bus2.tx_section_enable} = 20'h4240F;
    b2(1'b1, 1'b1, 1'b1, 1'b0);
    b2(1'b0, 1'b1, 1'b1, 1'b0);
    repeat (6) begin
      b2(1'b0, 1'b1, 1'b0, 1'b1);
      seen = seen | bus2.done_lvl;
    end
    b2(1'b0, 1'b1, 1'b1, 1'b0);
    chk({7'h00, seen}, 8'h00);
    chk({4'h0, tx_en2}, 8'h00);
    repeat (8) b2(1'b0, 1'b0, 1'b0, 1'b1);
    chk({7'h00, bus2.done_lvl}, 8'h01);
    b2(1'b0, 1'b1, 1'b1, 1'b0);
    chk({4'h0, tx_en2}, 8'h0F);
  endtask
  initial begin
    rstn_i = 1'b0;
    {host_mode, cpu_type, e1_mode, req, we, addr, wdata} = 22'h000000;
    {all_ones, tx_pin_en, tx_pos, tx_neg} = 16'h0000;
    {bus2.mode_sel_drv, bus2.mode_sel_oe, bus2.cpu_type_sel_lo, bus2.cpu_type_sel_hi, bus2.cpu_clk} = 5'h08;
    {bus2.wr_rw, bus2.read_or_data_strobe, bus2.address_latch_strobe, bus2.cs_n, bus2.rx_mute_pin} = 5'h1A;
    {bus2.addr, bus2.data_host, bus2.data_host_oe} = 17'h00000;
    {bus2.tx_section_enable, bus2.tx_line_clock, bus2.tx_positive_rail_in, bus2.tx_negative_rail_in} = 16'h0000;
    repeat (10) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    @(negedge clk_sys_i);
    t_hw();
    for (int t = 0; t < 4; t++) t_regs(2'(t));
    t_handover();
    t_line(1'b1, 1'b0);
    t_line(1'b0, 1'b1);
    t_fault();
    complete_run();
  end
endmodule
